// file: logic/dioem_mapper.sv
// digital input to calibration request mapper and status output driver
// assumes trigger pins are asynchronous; status inputs share sys_clk_i
`timescale 1ns/100ps
`default_nettype none
`include "dioem_defines.svh"

// Notes on behaviour
// - eight inputs, each none, span or zero
// - fire action when input enters active level
// - no-action input never fires, polarity forced low
// - span input active sets calibration to span
// - zero input active sets calibration to zero
// - per input polarity, high at 5V, low 0V
// - eight outputs, each one selectable status state
// - output active while its condition holds
// - per output polarity, high drives 1, low 0
// - disabled output state never becomes active
// - separate fault states for each subsystem
// - system fault means any fault, red indicator
// - background, span, zero, maintenance progress states
// - state for memory stick disconnected
// - state for analog output over-range scale
// - high background state above 1100 per Mm
// - over-range enters at 90 %, leaves 80 %
module dioem_mapper #(
    parameter int N     = `DIOEM_NUM_PINS,
    parameter int BG_W  = `DIOEM_BG_W,
    parameter int RNG_W = `DIOEM_RANGE_W
) (
    // clock and reset
    input  wire logic                      sys_clk_i,
    input  wire logic                      reset_i,
    // trigger pins and their configuration
    input  wire logic [N-1:0]              trigger_input_n_i,
    input  wire logic [N*`DIOEM_ACT_W-1:0] di_action_i,
    input  wire logic [N-1:0]              di_active_high_i,
    // calibration selection
    input  wire logic                      cal_done_i,
    output var  dioem_pkg::dioem_cal_t     cal_select_o,
    output var  logic                      span_request_o,
    output var  logic                      zero_request_o,
    // status conditions
    input  wire logic                      psu_fault_i,
    input  wire logic                      converter_fault_i,
    input  wire logic                      flow_fault_i,
    input  wire logic                      cell_heater_fault_i,
    input  wire logic                      flow_heater_fault_i,
    input  wire logic                      chassis_temp_fault_i,
    input  wire logic                      interface_board_fault_i,
    input  wire logic                      signal_fault_i,
    input  wire logic                      other_fault_i,
    input  wire logic                      stick_absent_i,
    input  wire logic                      background_busy_i,
    input  wire logic                      span_busy_i,
    input  wire logic                      zero_busy_i,
    input  wire logic                      maintenance_i,
    input  wire logic [BG_W-1:0]           background_i,
    // analog output scale
    input  wire logic [RNG_W-1:0]          ao_reading_i,
    input  wire logic [RNG_W-1:0]          ao_std_range_i,
    input  wire logic                      ao_overrange_en_i,
    output var  logic                      analog_out_overrange_o,
    // output pins and their configuration
    input  wire logic [N*`DIOEM_STATE_W-1:0] do_state_sel_i,
    input  wire logic [N-1:0]              do_active_high_i,
    output var  logic [N-1:0]              do_pin_o,
    output var  logic                      red_indicator_o
);
    import dioem_pkg::*;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic dioem_action_t action_of(
        input logic [N*`DIOEM_ACT_W-1:0] cfg,
        input int                        idx
    );
        logic [`DIOEM_ACT_W-1:0] raw;
        raw = cfg[idx*`DIOEM_ACT_W +: `DIOEM_ACT_W];
        if (raw == `DIOEM_ACT_SPAN) begin
            return DIOEM_ACT_SPAN;
        end else if (raw == `DIOEM_ACT_ZERO) begin
            return DIOEM_ACT_ZERO;
        end else begin
            // unused code behaves as no action
            return DIOEM_ACT_NONE;
        end
    endfunction : action_of

    function automatic logic state_true(
        input logic [`DIOEM_STATE_W-1:0]   sel,
        input logic [`DIOEM_NUM_STATES-1:0] conds
    );
        logic hit;
        hit = 1'b0;
        if (sel == `DIOEM_ST_DISABLED) begin
            hit = 1'b0;
        end else if (sel < `DIOEM_STATE_W'(`DIOEM_NUM_STATES)) begin
            hit = conds[sel];
        end
        return hit;
    endfunction : state_true

    // ----------------------------------------------------------------
    // input synchronisers
    // ----------------------------------------------------------------
    logic [N-1:0] sync1_reg;
    logic [N-1:0] sync2_reg;
    logic [N-1:0] sync3_reg;
    logic [N-1:0] level_reg;

    // pins idle high so the chain resets to one
    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            sync1_reg <= {N{`DIOEM_SYNC_RST}};
            sync2_reg <= {N{`DIOEM_SYNC_RST}};
            sync3_reg <= {N{`DIOEM_SYNC_RST}};
        end else begin
            sync1_reg <= trigger_input_n_i;
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
        end
    end

    // a level is accepted only when two stages agree
    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            level_reg <= {N{`DIOEM_SYNC_RST}};
        end else begin
            for (int i = 0; i < N; i++) begin
                if (sync2_reg[i] == sync3_reg[i]) begin
                    level_reg[i] <= sync3_reg[i];
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // active level and edge detection
    // ----------------------------------------------------------------
    logic [N-1:0] pol_high;
    logic [N-1:0] in_active;
    logic [N-1:0] active_prev_reg;
    logic [N-1:0] fire;

    always_comb begin
        for (int i = 0; i < N; i++) begin
            if (action_of(di_action_i, i) == DIOEM_ACT_NONE) begin
                pol_high[i]  = 1'b0;
                in_active[i] = 1'b0;
            end else begin
                pol_high[i]  = di_active_high_i[i];
                in_active[i] = pol_high[i] ? level_reg[i] : ~level_reg[i];
            end
        end
    end

    // reset to one: an active-high level already held at reset does not fire
    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            active_prev_reg <= {N{`DIOEM_PREV_RST}};
        end else begin
            active_prev_reg <= in_active;
        end
    end

    assign fire = in_active & ~active_prev_reg;

    // ----------------------------------------------------------------
    // calibration selection
    // ----------------------------------------------------------------
    logic       span_hit;
    logic       zero_hit;
    dioem_cal_t cal_reg;
    dioem_cal_t cal_next;

    // lowest numbered firing input wins when several fire together
    always_comb begin
        span_hit = 1'b0;
        zero_hit = 1'b0;
        for (int i = N - 1; i >= 0; i--) begin
            if (fire[i]) begin
                span_hit = (action_of(di_action_i, i) == DIOEM_ACT_SPAN);
                zero_hit = (action_of(di_action_i, i) == DIOEM_ACT_ZERO);
            end
        end
    end

    // a new request wins over a done arriving in the same cycle
    always_comb begin
        cal_next = cal_reg;
        case (cal_reg)
            DIOEM_CAL_IDLE,
            DIOEM_CAL_SPAN,
            DIOEM_CAL_ZERO: begin
                if (span_hit) begin
                    cal_next = DIOEM_CAL_SPAN;
                end else if (zero_hit) begin
                    cal_next = DIOEM_CAL_ZERO;
                end else if (cal_done_i) begin
                    cal_next = DIOEM_CAL_IDLE;
                end
            end
            default: begin
                cal_next = DIOEM_CAL_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            cal_reg <= DIOEM_CAL_IDLE;
        end else begin
            cal_reg <= cal_next;
        end
    end

    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            span_request_o <= 1'b0;
            zero_request_o <= 1'b0;
        end else begin
            span_request_o <= span_hit;
            zero_request_o <= zero_hit;
        end
    end

    assign cal_select_o = cal_reg;

    // ----------------------------------------------------------------
    // status conditions
    // ----------------------------------------------------------------
    logic                         any_fault;
    logic                         high_bg;
    logic                         overrange;
    logic [`DIOEM_NUM_STATES-1:0] conds;

    dioem_overrange #(
        .W           (RNG_W)
    ) u_overrange (
        .sys_clk_i   (sys_clk_i),
        .reset_i     (reset_i),
        .reading_i   (ao_reading_i),
        .std_range_i (ao_std_range_i),
        .enable_i    (ao_overrange_en_i),
        .overrange_o (overrange)
    );

    assign any_fault = psu_fault_i | converter_fault_i | flow_fault_i
                     | cell_heater_fault_i | flow_heater_fault_i
                     | chassis_temp_fault_i | interface_board_fault_i
                     | signal_fault_i | other_fault_i;

    // strictly above the limit, equal does not count
    assign high_bg = (background_i > BG_W'(`DIOEM_HIGH_BG_LIMIT));

    always_comb begin
        conds                        = '0;
        conds[`DIOEM_ST_PSU]         = psu_fault_i;
        conds[`DIOEM_ST_CONVERTER]   = converter_fault_i;
        conds[`DIOEM_ST_FLOW]        = flow_fault_i;
        conds[`DIOEM_ST_CELL_HEAT]   = cell_heater_fault_i;
        conds[`DIOEM_ST_FLOW_HEAT]   = flow_heater_fault_i;
        conds[`DIOEM_ST_CHASSIS]     = chassis_temp_fault_i;
        conds[`DIOEM_ST_STICK_OUT]   = stick_absent_i;
        conds[`DIOEM_ST_BACKGROUND]  = background_busy_i;
        conds[`DIOEM_ST_SPAN]        = span_busy_i;
        conds[`DIOEM_ST_ZERO]        = zero_busy_i;
        conds[`DIOEM_ST_SYS_FAULT]   = any_fault;
        conds[`DIOEM_ST_MAINT]       = maintenance_i;
        conds[`DIOEM_ST_OVERRANGE]   = overrange;
        conds[`DIOEM_ST_IFACE_BOARD] = interface_board_fault_i;
        conds[`DIOEM_ST_HIGH_BG]     = high_bg;
        conds[`DIOEM_ST_SIGNAL]      = signal_fault_i;
    end

    // ----------------------------------------------------------------
    // output pins
    // ----------------------------------------------------------------
    logic [N-1:0] do_cond;
    logic [N-1:0] do_pin_reg;
    logic         red_reg;

    always_comb begin
        for (int i = 0; i < N; i++) begin
            do_cond[i] = state_true(do_state_sel_i[i*`DIOEM_STATE_W +: `DIOEM_STATE_W],
                                    conds);
        end
    end

    // pins reset low whatever their polarity; config is unknown then
    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            do_pin_reg <= {N{`DIOEM_PIN_RST}};
        end else begin
            do_pin_reg <= do_cond ~^ do_active_high_i;
        end
    end

    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            red_reg <= 1'b0;
        end else begin
            red_reg <= any_fault;
        end
    end

    assign do_pin_o               = do_pin_reg;
    assign red_indicator_o        = red_reg;
    assign analog_out_overrange_o = overrange;

endmodule : dioem_mapper

`default_nettype wire

// file: logic/dioem_defines.svh
// constants for the digital input / output event mapper
// assumes nothing; included by the package, the mapper and the over-range selector
`ifndef DIOEM_DEFINES_SVH
`define DIOEM_DEFINES_SVH

// ----------------------------------------------------------------
// sizes
// ----------------------------------------------------------------
`define DIOEM_NUM_PINS       8
`define DIOEM_ACT_W          2
`define DIOEM_STATE_W        5
`define DIOEM_NUM_STATES     17
`define DIOEM_BG_W           16
`define DIOEM_RANGE_W        16

// ----------------------------------------------------------------
// input actions
// ----------------------------------------------------------------
`define DIOEM_ACT_NONE       2'h0
`define DIOEM_ACT_SPAN       2'h1
`define DIOEM_ACT_ZERO       2'h2

// ----------------------------------------------------------------
// output state codes
// ----------------------------------------------------------------
`define DIOEM_ST_DISABLED    5'h00
`define DIOEM_ST_PSU         5'h01
`define DIOEM_ST_CONVERTER   5'h02
`define DIOEM_ST_FLOW        5'h03
`define DIOEM_ST_CELL_HEAT   5'h04
`define DIOEM_ST_FLOW_HEAT   5'h05
`define DIOEM_ST_CHASSIS     5'h06
`define DIOEM_ST_STICK_OUT   5'h07
`define DIOEM_ST_BACKGROUND  5'h08
`define DIOEM_ST_SPAN        5'h09
`define DIOEM_ST_ZERO        5'h0A
`define DIOEM_ST_SYS_FAULT   5'h0B
`define DIOEM_ST_MAINT       5'h0C
`define DIOEM_ST_OVERRANGE   5'h0D
`define DIOEM_ST_IFACE_BOARD 5'h0E
`define DIOEM_ST_HIGH_BG     5'h0F
`define DIOEM_ST_SIGNAL      5'h10

// ----------------------------------------------------------------
// thresholds, in 1/Mm for background and percent of range
// ----------------------------------------------------------------
`define DIOEM_HIGH_BG_LIMIT  16'h044C
`define DIOEM_PCT_FULL       7'h64
`define DIOEM_OVR_ENTER_PCT  7'h5A
`define DIOEM_OVR_EXIT_PCT   7'h50

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define DIOEM_PIN_RST        1'h0
`define DIOEM_SYNC_RST       1'h1
`define DIOEM_PREV_RST       1'h1

`endif

// file: logic/dioem_pkg.sv
// types shared by the event mapper files
// assumes dioem_defines.svh is on the include path
`include "dioem_defines.svh"

package dioem_pkg;

    typedef enum logic [`DIOEM_ACT_W-1:0] {
        DIOEM_ACT_NONE = `DIOEM_ACT_NONE,
        DIOEM_ACT_SPAN = `DIOEM_ACT_SPAN,
        DIOEM_ACT_ZERO = `DIOEM_ACT_ZERO
    } dioem_action_t;

    // gray along idle -> span -> zero
    typedef enum logic [1:0] {
        DIOEM_CAL_IDLE = 2'h0,
        DIOEM_CAL_SPAN = 2'h1,
        DIOEM_CAL_ZERO = 2'h3
    } dioem_cal_t;

endpackage : dioem_pkg

// file: logic/dioem_overrange.sv
// analog output over-range scale selector with hysteresis
// assumes reading and range are unsigned, in the same units, same clock
`timescale 1ns/100ps
`default_nettype none
`include "dioem_defines.svh"

module dioem_overrange #(
    parameter int W = `DIOEM_RANGE_W
) (
    // clock and reset
    input  wire logic         sys_clk_i,
    input  wire logic         reset_i,
    // measurement
    input  wire logic [W-1:0] reading_i,
    input  wire logic [W-1:0] std_range_i,
    input  wire logic         enable_i,
    // scale in use
    output var  logic         overrange_o
);
    import dioem_pkg::*;

    logic [W+6:0] reading_pct;
    logic [W+6:0] enter_lvl;
    logic [W+6:0] exit_lvl;
    logic         overrange_reg;

    // products kept 7 bits wider so nothing is lost before the compare
    assign reading_pct = (W+7)'(reading_i) * (W+7)'(`DIOEM_PCT_FULL);
    assign enter_lvl   = (W+7)'(std_range_i) * (W+7)'(`DIOEM_OVR_ENTER_PCT);
    assign exit_lvl    = (W+7)'(std_range_i) * (W+7)'(`DIOEM_OVR_EXIT_PCT);

    // the gap between the two levels stops the scale chattering
    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            overrange_reg <= 1'b0;
        end else if (!enable_i) begin
            overrange_reg <= 1'b0;
        end else if (!overrange_reg && reading_pct >= enter_lvl) begin
            overrange_reg <= 1'b1;
        end else if (overrange_reg && reading_pct <= exit_lvl) begin
            overrange_reg <= 1'b0;
        end
    end

    assign overrange_o = overrange_reg;

endmodule : dioem_overrange

`default_nettype wire

// file: tb/dioem_mapper_chk.sv
// concurrent checks on the event mapper top ports
// assumes one clock domain; bound into every dioem_mapper instance
`timescale 1ns/100ps
`default_nettype none

module dioem_mapper_chk #(
    parameter int N     = 8,
    parameter int BG_W  = 16,
    parameter int RNG_W = 16
) (
    // clock and reset
    input wire logic                   sys_clk_i,
    input wire logic                   reset_i,
    // trigger side
    input wire logic [2*N-1:0]         di_action_i,
    input wire dioem_pkg::dioem_cal_t  cal_select_o,
    input wire logic                   span_request_o,
    input wire logic                   zero_request_o,
    // status side
    input wire logic                   psu_fault_i,
    input wire logic                   converter_fault_i,
    input wire logic                   flow_fault_i,
    input wire logic                   cell_heater_fault_i,
    input wire logic                   flow_heater_fault_i,
    input wire logic                   chassis_temp_fault_i,
    input wire logic                   interface_board_fault_i,
    input wire logic                   signal_fault_i,
    input wire logic                   other_fault_i,
    input wire logic [BG_W-1:0]        background_i,
    input wire logic [RNG_W-1:0]       ao_reading_i,
    input wire logic [RNG_W-1:0]       ao_std_range_i,
    input wire logic                   ao_overrange_en_i,
    input wire logic                   analog_out_overrange_o,
    input wire logic [N*5-1:0]         do_state_sel_i,
    input wire logic [N-1:0]           do_active_high_i,
    input wire logic [N-1:0]           do_pin_o,
    input wire logic                   red_indicator_o
);
    import dioem_pkg::*;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    logic             live_reg;
    logic [4:0]       sel0;
    logic             any_flt;
    logic [RNG_W+6:0] rd_pct;
    logic [RNG_W+6:0] hi90;
    logic [RNG_W+6:0] lo80;

    // $past is only trusted once one edge has passed since reset
    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) live_reg <= 1'h0;
        else live_reg <= 1'h1;
    end

    assign sel0    = do_state_sel_i[4:0];
    assign any_flt = psu_fault_i | converter_fault_i | flow_fault_i | cell_heater_fault_i
                   | flow_heater_fault_i | chassis_temp_fault_i | interface_board_fault_i
                   | signal_fault_i | other_fault_i;
    assign rd_pct  = {7'h00, ao_reading_i} * 7'h64;
    assign hi90    = {7'h00, ao_std_range_i} * 7'h5a;
    assign lo80    = {7'h00, ao_std_range_i} * 7'h50;

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (reset_i);

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    chk_span_once: assert property (span_request_o |=> !span_request_o)
        else $error("span request held past one cycle");
    chk_span_sets: assert property (span_request_o |-> cal_select_o == DIOEM_CAL_SPAN)
        else $error("span request without span selection");
    chk_zero_sets: assert property (zero_request_o |-> cal_select_o == DIOEM_CAL_ZERO)
        else $error("zero request without zero selection");
    chk_one_action: assert property (!(span_request_o && zero_request_o))
        else $error("span and zero fired together");
    chk_none_silent: assert property ((~|di_action_i) [*6] |-> !span_request_o && !zero_request_o)
        else $error("request with every input set to no action");
    chk_red_any: assert property (live_reg |-> red_indicator_o == $past(any_flt))
        else $error("red indicator not the or of faults");
    chk_psu_pin: assert property (live_reg && $past(sel0) == 5'h01 |->
        do_pin_o[0] == ($past(psu_fault_i) ~^ $past(do_active_high_i[0])))
        else $error("supply fault pin wrong level");
    chk_off_idle: assert property (live_reg && $past(sel0) == 5'h00 |->
        do_pin_o[0] == !$past(do_active_high_i[0]))
        else $error("disabled pin went active");
    chk_high_bg: assert property (live_reg && $past(sel0) == 5'h0f |->
        do_pin_o[0] == (($past(background_i) > 16'h044c) ~^ $past(do_active_high_i[0])))
        else $error("high background pin wrong level");
    chk_ovr_enter: assert property (live_reg && $rose(analog_out_overrange_o) |->
        $past(ao_overrange_en_i) && $past(rd_pct) >= $past(hi90))
        else $error("over-range entered below threshold");
    chk_ovr_leave: assert property (live_reg && $fell(analog_out_overrange_o) |->
        !$past(ao_overrange_en_i) || $past(rd_pct) <= $past(lo80))
        else $error("over-range left above threshold");

    cov_span: cover property (span_request_o);
    cov_zero: cover property (zero_request_o);
    cov_ovr: cover property ($rose(analog_out_overrange_o));

endmodule : dioem_mapper_chk

bind dioem_mapper dioem_mapper_chk #(.N(N), .BG_W(BG_W), .RNG_W(RNG_W)) u_chk (.*);

`default_nettype wire

// file: tb/dioem_logger.sv
// model of the external logger that drives the trigger pins
// assumes the bench says which inputs it wants asserted and their polarity
`timescale 1ns/100ps
`default_nettype none

module dioem_logger (
    // clock
    input  wire logic       sys_clk_i,
    // wanted assertion and pin polarity
    input  wire logic [7:0] want_i,
    input  wire logic [7:0] high_i,
    // trigger pins toward the device
    output var  logic [7:0] pin_o
);
    // pins move just after an edge, as a clocked logger output would
    always_ff @(posedge sys_clk_i) begin
        pin_o <= want_i ~^ high_i;
    end
endmodule : dioem_logger

`default_nettype wire

// file: tb/dioem_mapper_tb.sv
// self-checking bench for the event mapper
// assumes the logger model drives the trigger pins
`timescale 1ns/100ps
`default_nettype none

module dioem_mapper_tb;
    import dioem_pkg::*;

    logic        sys_clk_i;
    logic        reset_i;
    logic [7:0]  want;
    logic [7:0]  high;
    logic [7:0]  trig;
    logic [15:0] act;
    logic        cal_done;
    dioem_cal_t  cal_sel;
    logic        span_req;
    logic        zero_req;
    logic        ovr;
    logic        red;
    logic [16:0] stat;
    logic [15:0] ao_rd;
    logic        ao_en;
    logic [39:0] dsel;
    logic [7:0]  dhigh;
    logic [7:0]  dpin;
    int          span_cnt = 0;
    int          zero_cnt = 0;
    int          err_total = 0;
    int          checks_done = 0;
    int          s0;
    int          z0;
    logic [15:0] rd_tab [7] = '{16'h005a, 16'h0055, 16'h0051, 16'h0050, 16'h0059,
                                16'h005a, 16'h005a};
    logic [6:0]  ov_tab = 7'h27;

    dioem_logger u_log (.sys_clk_i(sys_clk_i), .want_i(want), .high_i(high), .pin_o(trig));

    dioem_mapper uut (
        .sys_clk_i(sys_clk_i), .reset_i(reset_i), .trigger_input_n_i(trig),
        .di_action_i(act), .di_active_high_i(high), .cal_done_i(cal_done),
        .cal_select_o(cal_sel), .span_request_o(span_req), .zero_request_o(zero_req),
        .psu_fault_i(stat[1]), .converter_fault_i(stat[2]), .flow_fault_i(stat[3]),
        .cell_heater_fault_i(stat[4]), .flow_heater_fault_i(stat[5]),
        .chassis_temp_fault_i(stat[6]), .stick_absent_i(stat[7]),
        .background_busy_i(stat[8]), .span_busy_i(stat[9]), .zero_busy_i(stat[10]),
        .other_fault_i(stat[11]), .maintenance_i(stat[12]),
        .interface_board_fault_i(stat[14]), .signal_fault_i(stat[16]),
        .background_i(stat[15] ? 16'h044d : 16'h044c), .ao_reading_i(ao_rd),
        .ao_std_range_i(16'h0064), .ao_overrange_en_i(ao_en),
        .analog_out_overrange_o(ovr), .do_state_sel_i(dsel), .do_active_high_i(dhigh),
        .do_pin_o(dpin), .red_indicator_o(red)
    );

    initial begin
        sys_clk_i = 1'h0;
        forever #25 sys_clk_i = ~sys_clk_i;
    end

    always @(posedge sys_clk_i) begin
        if (span_req) span_cnt <= span_cnt + 1;
        if (zero_req) zero_cnt <= zero_cnt + 1;
    end

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk_i);
    endtask : tick

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : check

    function automatic logic cond_of(input int code, input logic [16:0] s);
        if (code == 0) return 1'h0;
        if (code == 11) return |(s & 17'h1_487e);
        return s[code];
    endfunction : cond_of

    // every output k shows state (c+k) mod 17, so all codes meet all pins
    task automatic put(input int c, input logic [16:0] s);
        logic [7:0] e;
        @(posedge sys_clk_i);
        for (int k = 0; k < 8; k++) dsel[5*k +: 5] <= 5'((c + k) % 17);
        stat <= s;
        ao_rd <= s[13] ? 16'h005a : 16'h0000;
        tick(3);
        @(negedge sys_clk_i);
        for (int k = 0; k < 8; k++) e[k] = cond_of((c + k) % 17, s) ~^ dhigh[k];
        check("do_pin", dpin, e);
        check("red", red, |(s & 17'h1_487e));
    endtask : put

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : report_and_stop

    initial begin
        tick(5000);
        $display("watchdog expired");
        err_total++;
        report_and_stop();
    end

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        reset_i = 1'h1;
        want = 8'h00;
        high = 8'h00;
        act = 16'h0000;
        cal_done = 1'h0;
        stat = 17'h0_0000;
        ao_rd = 16'h0000;
        ao_en = 1'h1;
        dsel = 40'h00_0000_0000;
        dhigh = 8'h5a;
        tick(4);
        @(negedge sys_clk_i);
        check("rst_pin", dpin, 8'h00);
        check("rst_cal", cal_sel, DIOEM_CAL_IDLE);
        check("rst_req", {span_req, zero_req, red, ovr}, 4'h0);
        tick(1);
        reset_i <= 1'h0;
        tick(4);
        $display("test reset done");
        // polarity set high on a no-action input must change nothing
        s0 = span_cnt + zero_cnt;
        high[2] <= 1'h1;
        want[2] <= 1'h1;
        tick(8);
        want[2] <= 1'h0;
        tick(8);
        check("none_pulses", span_cnt + zero_cnt - s0, 32'h0);
        $display("test no-action done");
        for (int i = 0; i < 8; i++) begin
            tick(1);
            s0 = span_cnt;
            z0 = zero_cnt;
            // polarity settles first: an action set on a level already active would fire
            high[i] <= i[1];
            tick(6);
            act[2*i +: 2] <= i[0] ? DIOEM_ACT_ZERO : DIOEM_ACT_SPAN;
            tick(2);
            want[i] <= 1'h1;
            tick(12);
            want[i] <= 1'h0;
            tick(8);
            @(negedge sys_clk_i);
            check("cal_sel", cal_sel, i[0] ? DIOEM_CAL_ZERO : DIOEM_CAL_SPAN);
            check("span_pulses", span_cnt - s0, i[0] ? 32'h0 : 32'h1);
            check("zero_pulses", zero_cnt - z0, i[0] ? 32'h1 : 32'h0);
            tick(1);
            cal_done <= 1'h1;
            act[2*i +: 2] <= DIOEM_ACT_NONE;
            tick(1);
            cal_done <= 1'h0;
            tick(1);
            @(negedge sys_clk_i);
            check("cal_idle", cal_sel, DIOEM_CAL_IDLE);
        end
        $display("test triggers done");
        for (int c = 0; c < 17; c++) begin
            put(c, 17'h0_0001 << c);
            put(c, ~(17'h0_0001 << c));
        end
        $display("test states done");
        put(0, 17'h0_0000);
        for (int j = 0; j < 7; j++) begin
            @(posedge sys_clk_i);
            ao_rd <= rd_tab[j];
            ao_en <= (j != 6);
            tick(2);
            @(negedge sys_clk_i);
            check("overrange", ovr, ov_tab[j]);
        end
        $display("test over-range done");
        report_and_stop();
    end
endmodule : dioem_mapper_tb

`default_nettype wire
